// *** src/pport_pkg.sv ***
package pport_pkg;
    // register addresses on the 2-bit host address
    localparam logic [1:0] ADDR_DATA   = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_CTRL   = 2'h2;
    localparam logic [1:0] ADDR_AFR    = 2'h3;
    // fifo geometry
    localparam int FIFO_DEPTH = 83;
    localparam int CNT_W      = 7;
    localparam int PTR_W      = 7;
    // alternate function bits
    localparam int AFR_POL_BIT  = 6;
    localparam int AFR_FEN_BIT  = 7;
    localparam int AFR_TYPE_LO  = 4;
    localparam int AFR_TYPE_HI  = 5;
    localparam int AFR_SRC_BIT  = 3;
    // control register bits
    localparam int CON_STB_BIT  = 0;
    localparam int CON_AFD_BIT  = 1;
    localparam int CON_INIT_BIT = 2;
    localparam int CON_SLI_BIT  = 3;
    localparam int CON_IEN_BIT  = 4;
    localparam int CON_DIR_BIT  = 5;
    // reset values and fixed readback bits
    localparam logic [7:0] AFR_RESET = 8'h00;
    localparam logic [7:0] CON_RESET = 8'h00;
    localparam logic [2:0] COM_UNUSED = 3'h7;
    localparam logic [1:0] STR_LOW_ONES = 2'h3;
endpackage

// *** src/sync2.sv ***
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** src/byte_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module byte_fifo
    import pport_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             push,
    input  wire logic [7:0]       wdata,
    input  wire logic             pop,
    output logic      [7:0]       rdata,
    output logic      [CNT_W-1:0] count,
    output logic                  full,
    output logic                  empty
);
    localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] FULLC = CNT_W'(DEPTH);

    logic [7:0]       mem_q [DEPTH];
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] rd_q;
    logic [CNT_W-1:0] cnt_q;
    wire              do_push = push && (cnt_q != FULLC);  // R12
    wire              do_pop  = pop && (cnt_q != '0);

    assign rdata = mem_q[rd_q];
    assign count = cnt_q;
    assign full  = (cnt_q == FULLC);
    assign empty = (cnt_q == '0);

    // storage, written only while there is room
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_q] <= wdata; // R4
        end
    end

    // pointers and byte counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (clear) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    a_full_hold: assert property (@(posedge clk) disable iff (rst) // R12
        (full && push && !pop && !clear) |=> ($stable(cnt_q) && $stable(wr_q)))
        else $error("write into full fifo changed state");
    a_count_max: assert property (@(posedge clk) disable iff (rst) // R4
        cnt_q <= FULLC)
        else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** src/printer_port_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: on reset the data lines drive out, strobe and auto feed sit high, printer reset low and select-in high.
// R2: alternate function bit 6 inverts the interrupt output, which otherwise follows acknowledge; here only with type 00, else fifo empty (01) or full (1x).
// R3: alternate function bit 7 enables the output fifo, cleared to disabled at reset.
// R4: with the fifo enabled an 83-byte buffer holds bytes queued for the printer.
// R5: fifo level bits 6..0 give the number of bytes still waiting in the fifo.
// R6: the count field has bit 0 as its least and bit 6 as its most significant bit.
// R7: fifo level bit 7 reads 0 when the fifo is enabled and 1 when it is disabled.
// R8: the two address bits select the registers; shared addresses write control or config and read back the other.
// R9: status bits 1 and 0 read 1 unless both interrupt-type bits are set.
// R10: command readback bits 7 to 5 always read 1.
// R11: the host waits three clocks after an acknowledge or busy fall before reading the fifo level.
// R12: a data write into a full fifo is dropped, leaving contents and count unchanged.
module printer_port_regs
    import pport_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] addr,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic [7:0] parallel_data_lines_in,
    output logic      [7:0] parallel_data_lines_out,
    output logic            parallel_data_lines_oe,
    output logic            strobe_n,
    output logic            auto_feed_n,
    output logic            printer_init_n,
    output logic            select_in_n,
    input  wire logic       ack_n_in,
    input  wire logic       busy_in,
    input  wire logic       error_n_in,
    input  wire logic       printer_selected_in,
    input  wire logic       paper_empty_in,
    input  wire logic       fifo_pop,
    output logic            int_out,
    output logic            int_oe,
    output logic            fifo_enable,
    output logic      [1:0] int_type,
    output logic            handshake_busy,
    output logic      [2:0] strobe_timing,
    output logic      [6:0] fifo_level
);
    // synchronised host strobes and printer inputs
    logic [7:0] pd_s;
    logic [4:0] pin_s;
    logic [2:0] bus_s;
    sync2 #(.W(8)) u_pd_sync (
        .clk (clk),
        .rst (rst),
        .d   (parallel_data_lines_in),
        .q   (pd_s)
    );
    sync2 #(.W(8)) u_pin_sync (
        .clk (clk),
        .rst (rst),
        .d   ({ack_n_in, busy_in, error_n_in, printer_selected_in, paper_empty_in, ~cs_n, ~rd_n, ~wr_n}),
        .q   ({pin_s, bus_s})
    );
    wire ack_s  = pin_s[4];
    wire busy_s = pin_s[3];
    wire err_s  = pin_s[2];
    wire printer_selected_in_s = pin_s[1];
    wire pe_s   = pin_s[0];
    wire cs_s   = bus_s[2];
    wire rd_s   = bus_s[1];
    wire wr_s   = bus_s[0];

    // edge detect on strobes: one access per strobe
    logic rd_d1_q;
    logic wr_d1_q;
    logic ack_d1_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_d1_q  <= 1'b0;
            wr_d1_q  <= 1'b0;
            ack_d1_q <= 1'b0; // synchroniser resets low: no false fall after reset
        end else begin
            rd_d1_q  <= rd_s && cs_s;
            wr_d1_q  <= wr_s && cs_s;
            ack_d1_q <= ack_s;
        end
    end
    wire rd_pulse = rd_s && cs_s && !rd_d1_q;
    wire wr_pulse = wr_s && cs_s && !wr_d1_q;
    wire ack_fall = ack_d1_q && !ack_s;

    // address decode shared by read and write paths
    function automatic logic hit(input logic [1:0] a, input logic [1:0] reg_addr);
        return a == reg_addr;
    endfunction
    logic [7:0] wdata_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdata_q <= '0;
        end else begin
            wdata_q <= wdata;
        end
    end
    wire wr_data = wr_pulse && hit(addr, ADDR_DATA);  // R8
    wire wr_ctrl = wr_pulse && hit(addr, ADDR_CTRL);  // R8
    wire wr_afr  = wr_pulse && hit(addr, ADDR_AFR);   // R8
    wire rd_stat = rd_pulse && hit(addr, ADDR_STATUS);

    // control and alternate function registers
    logic [7:0] con_q;
    logic [7:0] afr_q;
    logic [7:0] port_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            con_q  <= CON_RESET; // R1
            afr_q  <= AFR_RESET; // R3
            port_q <= '0;
        end else begin
            if (wr_ctrl) begin
                con_q <= wdata_q;
            end
            if (wr_afr) begin
                afr_q <= wdata_q;
            end
            if (wr_data) begin
                port_q <= wdata_q;
            end
        end
    end
    wire fen = afr_q[AFR_FEN_BIT]; // R3
    wire dir_in = con_q[CON_DIR_BIT];

    // output fifo, cleared while disabled or in printer reset
    logic [7:0]       f_rdata;
    logic [CNT_W-1:0] f_count;
    logic             f_full;
    logic             f_empty;
    wire fifo_clear = !fen || !con_q[CON_INIT_BIT];
    byte_fifo #(.DEPTH(DEPTH)) u_fifo (
        .clk   (clk),
        .rst   (rst),
        .clear (fifo_clear),
        .push  (wr_data && fen),
        .wdata (wdata_q),
        .pop   (fifo_pop),
        .rdata (f_rdata),
        .count (f_count),
        .full  (f_full),
        .empty (f_empty)
    );

    // latched interrupt: set by acknowledge fall, cleared by status read
    logic int_pend_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_pend_q <= 1'b0;
        end else if (ack_fall) begin
            int_pend_q <= 1'b1;
        end else if (rd_stat) begin
            int_pend_q <= 1'b0;
        end
    end

    // read data assembly
    wire [1:0] str_low   = (afr_q[AFR_TYPE_HI:AFR_TYPE_LO] == 2'h3) ? 2'h0 : STR_LOW_ONES; // R9
    wire       str_top   = fen ? !f_full : !busy_s;
    wire [7:0] str_val   = {str_top, ack_s, pe_s, printer_selected_in_s, err_s, !int_pend_q, str_low};
    wire [7:0] com_val   = {COM_UNUSED, con_q[CON_IEN_BIT], !select_in_n, printer_init_n, // R10
                            !auto_feed_n, !strobe_n};
    wire [7:0] level_val = {!fen, f_count};                                    // R5 R6 R7
    wire [7:0] pr_val    = dir_in ? pd_s : (fen ? f_rdata : port_q);
    logic [7:0] rd_mux;
    always_comb begin
        case (addr) // R8
            ADDR_DATA:   rd_mux = pr_val;
            ADDR_STATUS: rd_mux = str_val;
            ADDR_CTRL:   rd_mux = com_val;
            ADDR_AFR:    rd_mux = level_val;
            default:     rd_mux = 8'h00;
        endcase
    end

    // interrupt level and polarity
    wire int_src = afr_q[AFR_TYPE_HI] ? f_full : (afr_q[AFR_TYPE_LO] ? f_empty : ack_s);
    wire int_lvl = int_src ^ afr_q[AFR_POL_BIT]; // R2

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata                   <= '0;
            parallel_data_lines_out <= '0;
            parallel_data_lines_oe  <= 1'b1; // R1
            strobe_n                <= 1'b1; // R1
            auto_feed_n             <= 1'b1; // R1
            printer_init_n          <= 1'b0; // R1
            select_in_n             <= 1'b1; // R1
            int_out                 <= 1'b0;
            int_oe                  <= 1'b0;
            fifo_enable             <= 1'b0;
            int_type                <= '0;
            handshake_busy          <= 1'b0;
            strobe_timing           <= '0;
            fifo_level              <= '0;
        end else begin
            rdata                   <= rd_mux;
            parallel_data_lines_out <= fen ? f_rdata : port_q;
            parallel_data_lines_oe  <= !dir_in;
            strobe_n                <= !con_q[CON_STB_BIT];
            auto_feed_n             <= !con_q[CON_AFD_BIT];
            printer_init_n          <= con_q[CON_INIT_BIT];
            select_in_n             <= !con_q[CON_SLI_BIT];
            int_out                 <= int_lvl;
            int_oe                  <= con_q[CON_IEN_BIT];
            fifo_enable             <= fen;
            int_type                <= afr_q[AFR_TYPE_HI:AFR_TYPE_LO];
            handshake_busy          <= afr_q[AFR_SRC_BIT];
            strobe_timing           <= afr_q[2:0];
            fifo_level              <= f_count;
        end
    end

    // assertions
    sequence s_afr_write;
        wr_afr;
    endsequence
    sequence s_out_settle;
        ##2 1'b1;
    endsequence
    a_pol_invert: assert property (@(posedge clk) disable iff (rst) // R2
        int_out == ($past(int_src) ^ $past(afr_q[AFR_POL_BIT])))
        else $error("interrupt polarity wrong");
    a_fifo_enable: assert property (@(posedge clk) disable iff (rst) // R3
        s_afr_write |=> (fen == $past(wdata_q[AFR_FEN_BIT])) ##1 (fifo_enable == fen))
        else $error("fifo enable not taken");
    a_level_state: assert property (@(posedge clk) disable iff (rst) // R7
        rd_mux[7] == !fen || addr != ADDR_AFR)
        else $error("fifo state bit wrong");
    a_level_count: assert property (@(posedge clk) disable iff (rst) // R5
        (addr == ADDR_AFR) |-> (rd_mux[6:0] == f_count))
        else $error("fifo count readback wrong");
    a_status_low: assert property (@(posedge clk) disable iff (rst) // R9
        (addr == ADDR_STATUS) |-> (rd_mux[1:0] == ((afr_q[5:4] == 2'h3) ? 2'h0 : 2'h3)))
        else $error("status low bits wrong");
    a_com_ones: assert property (@(posedge clk) disable iff (rst) // R10
        (addr == ADDR_CTRL) |-> (rd_mux[7:5] == 3'h7))
        else $error("command unused bits not one");
    a_ctrl_write: assert property (@(posedge clk) disable iff (rst) // R8
        wr_ctrl |=> (con_q == $past(wdata_q)) and (afr_q == $past(afr_q)))
        else $error("control write misrouted");
    a_strobe_drive: assert property (@(posedge clk) disable iff (rst) // R1
        wr_ctrl |-> s_out_settle ##0 (strobe_n == !con_q[CON_STB_BIT]))
        else $error("strobe output not following control");
    a_disabled_empty: assert property (@(posedge clk) disable iff (rst) // R3
        !fen |=> (f_count == '0))
        else $error("disabled fifo holds data");
endmodule
`default_nettype wire

// *** test/printer_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// printer on the far end of the cable: answers each strobe with busy and an ack pulse
module printer_model #(
    parameter int BUSY_DLY = 2,
    parameter int ACK_W    = 12
) (
    input  wire logic clk,
    input  wire logic strobe_n,
    output logic      ack_n,
    output logic      busy,
    output logic      error_n,
    output logic      selected,
    output logic      paper_empty
);
    // idle levels of a ready printer with paper loaded
    initial begin
        ack_n = 1'b1;
        busy = 1'b0;
        error_n = 1'b1;
        selected = 1'b1;
        paper_empty = 1'b0;
    end
    // busy first, then ack low for ACK_W clocks, then ready again
    always @(negedge strobe_n) begin
        repeat (BUSY_DLY) @(negedge clk);
        busy = 1'b1;
        @(negedge clk);
        ack_n = 1'b0;
        repeat (ACK_W) @(negedge clk);
        ack_n = 1'b1;
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; $display("ERROR %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
    import pport_pkg::*;
    typedef struct packed {logic [7:0] e; logic [7:0] m;} note_t;
    logic       clk, rst, cs_n, rd_n, wr_n, fifo_pop, smp;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, lf, v;
    logic       strobe_n, auto_feed_n, printer_init_n, select_in_n, ack_n, busy, err_n, sel, pe;
    logic       int_out, int_oe, fifo_enable, pdl_oe, hsb;
    logic [2:0] st;
    logic [7:0] pdl_out;
    logic [1:0] int_type;
    logic [6:0] fifo_level;
    wire  [7:0] pdl_in = ~lf;
    note_t      nq[$];
    note_t      n;
    int         err_total, total_checks, cyc;

    printer_port_regs printer_port_regs_inst (.clk(clk), .rst(rst), .addr(addr), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .wdata(wdata), .rdata(rdata), .parallel_data_lines_in(pdl_in), .parallel_data_lines_out(pdl_out),
        .parallel_data_lines_oe(pdl_oe), .strobe_n(strobe_n), .auto_feed_n(auto_feed_n),
        .printer_init_n(printer_init_n), .select_in_n(select_in_n), .ack_n_in(ack_n), .busy_in(busy),
        .error_n_in(err_n), .printer_selected_in(sel), .paper_empty_in(pe), .fifo_pop(fifo_pop),
        .int_out(int_out), .int_oe(int_oe), .fifo_enable(fifo_enable), .int_type(int_type),
        .handshake_busy(hsb), .strobe_timing(st), .fifo_level(fifo_level));
    printer_model printer_model_inst (.clk(clk), .strobe_n(strobe_n), .ack_n(ack_n), .busy(busy),
        .error_n(err_n), .selected(sel), .paper_empty(pe));

    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // host write: strobe low four clocks, then high four clocks
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // host read: note the masked expectation, flag the sampling edge
    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge clk);
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (4) @(negedge clk);
        nq.push_back('{e: e, m: m});
        smp = 1'b1;
        @(negedge clk);
        smp = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    task automatic end_sim();
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always #2 clk = ~clk;
    // read data watcher
    always @(posedge clk) begin
        if (smp) begin
            n = nq.pop_front();
            `CHK("rdata", rdata & n.m, n.e)
        end
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        clk = 0; rst = 1; addr = 0; cs_n = 1; rd_n = 1; wr_n = 1; wdata = 0; fifo_pop = 0; smp = 0;
        lf = 8'h09; err_total = 0; total_checks = 0; cyc = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        `CHK("pins", {pdl_oe, strobe_n, auto_feed_n, printer_init_n, select_in_n}, 5'h1D)
        `CHK("fifo_enable", fifo_enable, 1'b0)
        rd(ADDR_CTRL, 8'hE0, 8'hFF);
        rd(ADDR_AFR, 8'h80, 8'hFF);
        `CHK("int_out", int_out, 1'b1)
        // strobe the printer and watch the interrupt follow ack
        wr(ADDR_CTRL, 8'h05);
        for (int i = 0; i < 100 && ack_n !== 1'b0; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        `CHK("int_out", int_out, 1'b0)
        wr(ADDR_CTRL, 8'h04);
        repeat (20) @(negedge clk);
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_AFR, 8'((t << 4) | (t << 2) | t));
            `CHK("int_type", int_type, 2'(t))
            `CHK("afr_low", {hsb, st}, 4'(((t << 2) | t) & 15))
            rd(ADDR_STATUS, (t == 3) ? 8'h00 : 8'h01, 8'h01);
        end
        wr(ADDR_AFR, 8'h40);
        `CHK("int_out", int_out, 1'b0)
        // random control values reach pins and read back
        for (int i = 0; i < 4; i++) begin
            lf = nxt(lf);
            v = lf & 8'h1E;
            wr(ADDR_CTRL, v);
            `CHK("ctrl", {auto_feed_n, printer_init_n, select_in_n, int_oe}, {~v[1], v[2], ~v[3], v[4]})
            rd(ADDR_CTRL, {3'h7, v[4:0]}, 8'hFF);
        end
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_AFR, 8'h80);
        `CHK("fifo_enable", fifo_enable, 1'b1)
        rd(ADDR_AFR, 8'h00, 8'hFF);
        wr(ADDR_DATA, lf);
        rd(ADDR_AFR, 8'h01, 8'hFF);
        `CHK("pd_out", pdl_out, lf)
        for (int i = 1; i < FIFO_DEPTH; i++) begin
            lf = nxt(lf);
            wr(ADDR_DATA, lf);
        end
        rd(ADDR_AFR, 8'h53, 8'hFF);
        `CHK("fifo_level", fifo_level, 7'h53)
        rd(ADDR_STATUS, 8'h03, 8'h83);
        wr(ADDR_DATA, 8'hA5);
        rd(ADDR_AFR, 8'h53, 8'hFF);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            fifo_pop = 1'b1;
            @(negedge clk);
            fifo_pop = 1'b0;
        end
        repeat (3) @(negedge clk);
        rd(ADDR_AFR, 8'h51, 8'hFF);
        rd(ADDR_STATUS, 8'h83, 8'h83);
        wr(ADDR_AFR, 8'h00);
        `CHK("fifo_enable", fifo_enable, 1'b0)
        rd(ADDR_AFR, 8'h80, 8'hFF);
        end_sim();
    end
endmodule
`default_nettype wire
